// ### hdl/usdb_baud_gen.sv
`timescale 1ns/10ps
module usdb_baud_gen #(
  parameter int BASE_DIV = 64,
  parameter int OVERSAMPLE = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // divisor selection
  input usdb_pkg::usdb_baud_cfg_t cfg_i,
  // one pulse per receiver sample slot
  output logic sample_tick_o
);
  localparam int SUB_DIV = BASE_DIV / OVERSAMPLE;

  if (BASE_DIV % OVERSAMPLE != 0 || SUB_DIV < 1 || SUB_DIV > 4) begin : g_chk
    $error("usdb_baud_gen: divider parameters not supported");
  end

  function automatic logic [3:0] prescale_divisor(input logic [1:0] code);
    case (code)
      2'h0: prescale_divisor = 4'h1;
      2'h1: prescale_divisor = 4'h3;
      2'h2: prescale_divisor = 4'h4;
      default: prescale_divisor = 4'hd;
    endcase
  endfunction : prescale_divisor

  logic [7:0] pre_cnt;
  logic [7:0] pre_limit;
  logic [6:0] rate_cnt;
  logic [6:0] rate_limit;
  logic pre_wrap;

  assign pre_limit = 8'(SUB_DIV) * {4'h0, prescale_divisor(cfg_i.prescale_code)} - 8'h01;
  assign rate_limit = 7'((8'h01 << cfg_i.rate_code) - 8'h01);
  assign pre_wrap = (pre_cnt >= pre_limit);

  // compare with >= so a smaller divisor written mid-count wraps at once
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || pre_wrap) begin
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || (pre_wrap && rate_cnt >= rate_limit)) begin
      rate_cnt <= 7'h00;
    end else if (pre_wrap) begin
      rate_cnt <= rate_cnt + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sample_tick_o <= 1'b0;
    end else begin
      sample_tick_o <= pre_wrap && (rate_cnt >= rate_limit);
    end
  end
endmodule : usdb_baud_gen

// ### hdl/usdb_serial.sv
// How it works
// - low stop bit sets framing flag, irq
// - status-one read then data read clears framing
// - parity mismatch sets parity flag, irq
// - status-one read then data read clears parity
// - break sets break, framing, full; ninth cleared
// - break flag never raises an interrupt
// - status-two read then data read clears break
// - break re-arms only after line high
// - low in first slot sets reception flag
// - false start or idle clears reception flag
// - data read gives rx byte, write tx
// - prescale code picks 1, 3, 4, 13
// - rate code picks power-of-two divisor
// - bit rate is clock over 64*PD*BD
// - ninth bit captured with the byte
`timescale 1ns/10ps
`include "usdb_regs.svh"
module usdb_serial #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // serial line and transmitter hand-off
  input wire logic rxd_i,
  output logic [7:0] tx_data_o,
  output logic tx_load_o,
  // interrupts
  output logic err_irq_o,
  output logic irq_o
);
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
    $error("usdb_serial: ADDR_W out of range");
  end

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addr_hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs[7:2]));
  endfunction : addr_hit

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = addr_hit(a, `USDB_OFS_STAT_ONE) || addr_hit(a, `USDB_OFS_STAT_TWO) ||
      addr_hit(a, `USDB_OFS_DATA) || addr_hit(a, `USDB_OFS_CTRL_THREE) ||
      addr_hit(a, `USDB_OFS_RATE) || addr_hit(a, `USDB_OFS_IRQ_STAT) ||
      addr_hit(a, `USDB_OFS_IRQ_MASK);
  endfunction : addr_mapped

  // control fields
  usdb_pkg::usdb_baud_cfg_t baud_cfg;
  logic mode9;
  logic par_en;
  logic par_odd;
  logic framing_error_irq_enable;
  logic parity_error_irq_enable;
  logic [2:0] irq_mask;
  logic [2:0] irq_stat;

  // flags and buffer
  logic framing_error_flag;
  logic parity_error_flag;
  logic receiver_full_flag;
  logic break_detected_flag;
  logic reception_active_flag;
  logic received_ninth_bit;
  logic [7:0] rx_data;
  logic arm_fe;
  logic arm_pe;
  logic arm_rf;
  logic arm_bk;

  // receiver
  logic rxd_meta;
  logic rxd_sync;
  logic sample_tick;
  usdb_pkg::usdb_rx_state_t rx_state;
  logic [3:0] slot;
  logic [3:0] bit_idx;
  logic [8:0] shreg;
  logic [8:0] rx_char;
  logic [7:0] idle_cnt;
  logic break_armed;
  logic stop_evt;
  logic stop_low;
  logic is_break;
  logic par_bad;
  logic false_start;
  logic first_slot_low;
  logic idle_evt;
  usdb_pkg::usdb_event_t evt;

  // bus
  logic wr_go;
  logic rd_go;
  logic wr_en;
  logic rd_data_evt;
  logic rd_s1_evt;
  logic rd_s2_evt;
  logic [31:0] rd_word;

  // the first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd_i;
      rxd_sync <= rxd_meta;
    end
  end

  usdb_baud_gen #(
    .BASE_DIV(64),
    .OVERSAMPLE(16)
  ) u_baud (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .cfg_i(baud_cfg),
    .sample_tick_o(sample_tick)
  );

  assign rx_char = mode9 ? shreg : {1'b0, shreg[8:1]};
  assign stop_evt = sample_tick && (rx_state == usdb_pkg::RX_STOP) && (slot == `USDB_MID_SLOT);
  assign stop_low = stop_evt && !rxd_sync;
  assign is_break = stop_low && (rx_char == 9'h000);
  assign par_bad = stop_evt && par_en && ((^rx_char) != par_odd);
  assign false_start = sample_tick && (rx_state == usdb_pkg::RX_START) &&
    (slot == `USDB_MID_SLOT) && rxd_sync;
  assign first_slot_low = sample_tick && (rx_state == usdb_pkg::RX_SEARCH) && !rxd_sync;
  assign idle_evt = sample_tick && (rx_state == usdb_pkg::RX_SEARCH) && rxd_sync &&
    (idle_cnt == `USDB_IDLE_SLOTS - 8'h01);
  assign evt = '{rx_full: stop_evt, parity: par_bad, framing: stop_low};

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_state <= usdb_pkg::RX_SEARCH;
      slot <= 4'h0;
      bit_idx <= 4'h0;
      shreg <= 9'h000;
    end else if (sample_tick) begin
      case (rx_state)
        usdb_pkg::RX_SEARCH: begin
          bit_idx <= 4'h0;
          slot <= 4'h1;
          if (!rxd_sync) begin
            rx_state <= usdb_pkg::RX_START;
          end
        end
        usdb_pkg::RX_START: begin
          slot <= slot + 4'h1;
          if (false_start) begin
            rx_state <= usdb_pkg::RX_SEARCH;
          end else if (slot == `USDB_LAST_SLOT) begin
            rx_state <= usdb_pkg::RX_DATA;
          end
        end
        usdb_pkg::RX_DATA: begin
          slot <= slot + 4'h1;
          if (slot == `USDB_MID_SLOT) begin
            shreg <= {rxd_sync, shreg[8:1]};
            bit_idx <= bit_idx + 4'h1;
          end
          if (slot == `USDB_LAST_SLOT && bit_idx == (mode9 ? 4'h9 : 4'h8)) begin
            rx_state <= usdb_pkg::RX_STOP;
          end
        end
        usdb_pkg::RX_STOP: begin
          slot <= slot + 4'h1;
          if (slot == `USDB_MID_SLOT) begin
            rx_state <= usdb_pkg::RX_SEARCH;
          end
        end
        default: rx_state <= usdb_pkg::RX_SEARCH;
      endcase
    end
  end

  // idle character: ten bit times of high while searching
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || rx_state != usdb_pkg::RX_SEARCH || !rxd_sync) begin
      idle_cnt <= 8'h00;
    end else if (sample_tick && idle_cnt != `USDB_IDLE_SLOTS) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  // data buffer survives reset on purpose
  always_ff @(posedge sys_clk_i) begin
    if (stop_evt) begin
      rx_data <= rx_char[7:0];
      received_ninth_bit <= mode9 ? (rx_char[8] && !is_break) : rx_char[7];
    end
  end

  // read of the status register arms the clear; data read completes it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || rd_data_evt) begin
      arm_fe <= 1'b0;
      arm_pe <= 1'b0;
      arm_rf <= 1'b0;
      arm_bk <= 1'b0;
    end else begin
      if (rd_s1_evt) begin
        arm_fe <= framing_error_flag;
        arm_pe <= parity_error_flag;
        arm_rf <= receiver_full_flag;
      end
      if (rd_s2_evt) begin
        arm_bk <= break_detected_flag;
      end
    end
  end

  // a new event wins over the clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      framing_error_flag <= 1'b0;
    end else if (stop_low) begin
      framing_error_flag <= 1'b1;
    end else if (rd_data_evt && arm_fe) begin
      framing_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      parity_error_flag <= 1'b0;
    end else if (par_bad) begin
      parity_error_flag <= 1'b1;
    end else if (rd_data_evt && arm_pe) begin
      parity_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      receiver_full_flag <= 1'b0;
    end else if (stop_evt) begin
      receiver_full_flag <= 1'b1;
    end else if (rd_data_evt && arm_rf) begin
      receiver_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      break_armed <= 1'b1;
    end else if (is_break) begin
      break_armed <= 1'b0;
    end else if (rxd_sync) begin
      break_armed <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      break_detected_flag <= 1'b0;
    end else if (is_break && break_armed) begin
      break_detected_flag <= 1'b1;
    end else if (rd_data_evt && arm_bk) begin
      break_detected_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reception_active_flag <= 1'b0;
    end else if (first_slot_low) begin
      reception_active_flag <= 1'b1;
    end else if (false_start || idle_evt) begin
      reception_active_flag <= 1'b0;
    end
  end

  // break has no status bit here, so it cannot interrupt
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_stat <= 3'h0;
      err_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_en && addr_hit(s_axi_awaddr_i, `USDB_OFS_IRQ_STAT)) ?
        s_axi_wdata_i[2:0] : 3'h0)) | evt;
      err_irq_o <= (framing_error_flag && framing_error_irq_enable) ||
        (parity_error_flag && parity_error_irq_enable);
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // write side: address and data are taken together
  assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign wr_en = wr_go && s_axi_wstrb_i[0];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `USDB_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= addr_mapped(s_axi_awaddr_i) ? `USDB_RESP_OKAY : `USDB_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      baud_cfg <= '{prescale_code: `USDB_RST_PS, rate_code: `USDB_RST_RS};
      {mode9, par_en, par_odd, framing_error_irq_enable, parity_error_irq_enable} <=
        `USDB_RST_CTRL;
      irq_mask <= `USDB_RST_MASK;
    end else if (wr_en) begin
      if (addr_hit(s_axi_awaddr_i, `USDB_OFS_RATE)) begin
        baud_cfg.prescale_code <= s_axi_wdata_i[`USDB_RATE_PS_LSB +: 2];
        baud_cfg.rate_code <= s_axi_wdata_i[`USDB_RATE_RS_LSB +: 3];
      end
      if (addr_hit(s_axi_awaddr_i, `USDB_OFS_CTRL_THREE)) begin
        mode9 <= s_axi_wdata_i[`USDB_C3_MODE9];
        par_en <= s_axi_wdata_i[`USDB_C3_PAR_EN];
        par_odd <= s_axi_wdata_i[`USDB_C3_PAR_ODD];
        framing_error_irq_enable <= s_axi_wdata_i[`USDB_C3_FRAMING_ERROR_IRQ_ENABLE];
        parity_error_irq_enable <= s_axi_wdata_i[`USDB_C3_PARITY_ERROR_IRQ_ENABLE];
      end
      if (addr_hit(s_axi_awaddr_i, `USDB_OFS_IRQ_MASK)) begin
        irq_mask <= s_axi_wdata_i[2:0];
      end
    end
  end

  // transmit byte goes to the shifter outside; reads never see it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_load_o <= 1'b0;
    end else begin
      tx_load_o <= wr_en && addr_hit(s_axi_awaddr_i, `USDB_OFS_DATA);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_data_o <= 8'h00;
    end else if (wr_en && addr_hit(s_axi_awaddr_i, `USDB_OFS_DATA)) begin
      tx_data_o <= s_axi_wdata_i[7:0];
    end
  end

  // read side
  assign rd_go = s_axi_arvalid_i && !s_axi_rvalid_o;
  assign s_axi_arready_o = rd_go;
  assign rd_data_evt = rd_go && addr_hit(s_axi_araddr_i, `USDB_OFS_DATA);
  assign rd_s1_evt = rd_go && addr_hit(s_axi_araddr_i, `USDB_OFS_STAT_ONE);
  assign rd_s2_evt = rd_go && addr_hit(s_axi_araddr_i, `USDB_OFS_STAT_TWO);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (addr_hit(s_axi_araddr_i, `USDB_OFS_STAT_ONE)) begin
      rd_word[`USDB_S1_RXFULL] = receiver_full_flag;
      rd_word[`USDB_S1_FE] = framing_error_flag;
      rd_word[`USDB_S1_PE] = parity_error_flag;
    end
    if (addr_hit(s_axi_araddr_i, `USDB_OFS_STAT_TWO)) begin
      rd_word[`USDB_S2_BKF] = break_detected_flag;
      rd_word[`USDB_S2_RPF] = reception_active_flag;
    end
    if (addr_hit(s_axi_araddr_i, `USDB_OFS_DATA)) begin
      rd_word[7:0] = rx_data;
    end
    if (addr_hit(s_axi_araddr_i, `USDB_OFS_CTRL_THREE)) begin
      rd_word[`USDB_C3_NINTH] = received_ninth_bit;
      rd_word[`USDB_C3_MODE9] = mode9;
      rd_word[`USDB_C3_PAR_EN] = par_en;
      rd_word[`USDB_C3_PAR_ODD] = par_odd;
      rd_word[`USDB_C3_FRAMING_ERROR_IRQ_ENABLE] = framing_error_irq_enable;
      rd_word[`USDB_C3_PARITY_ERROR_IRQ_ENABLE] = parity_error_irq_enable;
    end
    if (addr_hit(s_axi_araddr_i, `USDB_OFS_RATE)) begin
      rd_word[`USDB_RATE_PS_LSB +: 2] = baud_cfg.prescale_code;
      rd_word[`USDB_RATE_RS_LSB +: 3] = baud_cfg.rate_code;
    end
    if (addr_hit(s_axi_araddr_i, `USDB_OFS_IRQ_STAT)) begin
      rd_word[2:0] = irq_stat;
    end
    if (addr_hit(s_axi_araddr_i, `USDB_OFS_IRQ_MASK)) begin
      rd_word[2:0] = irq_mask;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `USDB_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= addr_mapped(s_axi_araddr_i) ? `USDB_RESP_OKAY : `USDB_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // helper: cycles between sample ticks under a steady divisor
  logic [15:0] tick_gap;
  logic cfg_steady;
  logic [15:0] gap_expect;
  assign gap_expect = 16'(16'h0004 * (baud_cfg.prescale_code == 2'h0 ? 16'h0001 :
    baud_cfg.prescale_code == 2'h1 ? 16'h0003 : baud_cfg.prescale_code == 2'h2 ?
    16'h0004 : 16'h000d) * (16'h0001 << baud_cfg.rate_code));

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || sample_tick) begin
      tick_gap <= 16'h0001;
      cfg_steady <= !srst_i;
    end else begin
      tick_gap <= tick_gap + 16'h0001;
      if (wr_en && addr_hit(s_axi_awaddr_i, `USDB_OFS_RATE)) begin
        cfg_steady <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_fe_on_stop: assert property (stop_low |=> framing_error_flag)
    else $error("framing flag not set by low stop bit");
  a_fe_irq_path: assert property (stop_low && framing_error_irq_enable |=> ##1 err_irq_o)
    else $error("framing error did not raise error irq");
  a_fe_clear_seq: assert property (rd_data_evt && arm_fe && !stop_low |=> !framing_error_flag)
    else $error("framing flag not cleared by sequence");
  a_pe_on_bad: assert property (par_bad |=> parity_error_flag)
    else $error("parity flag not set");
  a_pe_hold: assert property (parity_error_flag && !(rd_data_evt && arm_pe) |=> parity_error_flag)
    else $error("parity flag lost without clear sequence");
  a_break_sets: assert property (is_break && break_armed |=>
    break_detected_flag && framing_error_flag && receiver_full_flag &&
    !(mode9 && received_ninth_bit))
    else $error("break did not set its flags");
  a_break_no_irq: assert property (break_detected_flag && !framing_error_flag &&
    !parity_error_flag |=> !err_irq_o)
    else $error("break flag caused interrupt");
  a_bk_clear_seq: assert property (rd_data_evt && arm_bk && !is_break |=> !break_detected_flag)
    else $error("break flag not cleared by sequence");
  a_bk_rearm: assert property ($rose(break_detected_flag) |-> $past(break_armed))
    else $error("break flag set without line high");
  a_rpf_set: assert property (first_slot_low |=> reception_active_flag)
    else $error("reception flag not set in first slot");
  a_rpf_clear: assert property ((false_start || idle_evt) |=> !reception_active_flag)
    else $error("reception flag not cleared");
  a_buf_capture: assert property (stop_evt && mode9 |=>
    rx_data == $past(shreg[7:0]) && received_ninth_bit == ($past(shreg[8]) && !$past(is_break)))
    else $error("buffer or ninth bit capture wrong");
  a_tick_rate: assert property (sample_tick && cfg_steady |-> tick_gap == gap_expect)
    else $error("sample tick spacing wrong");
  a_err_irq_off: assert property (!framing_error_irq_enable && !parity_error_irq_enable
    ##1 !framing_error_irq_enable && !parity_error_irq_enable |-> !err_irq_o)
    else $error("error irq without enabled flag");

  c_break: cover property (is_break && break_armed);
  c_false_start: cover property (false_start);
  c_parity_irq: cover property (par_bad && parity_error_irq_enable);
  c_idle: cover property (idle_evt);
endmodule : usdb_serial

// ### include/usdb_pkg.sv
package usdb_pkg;
  typedef enum logic [1:0] {RX_SEARCH, RX_START, RX_DATA, RX_STOP} usdb_rx_state_t;
  typedef struct packed {
    logic [1:0] prescale_code;
    logic [2:0] rate_code;
  } usdb_baud_cfg_t;
  typedef struct packed {
    logic rx_full;
    logic parity;
    logic framing;
  } usdb_event_t;
endpackage : usdb_pkg

// ### include/usdb_regs.svh
`ifndef USDB_REGS_SVH
`define USDB_REGS_SVH
// register byte offsets
`define USDB_OFS_STAT_ONE 8'h10
`define USDB_OFS_STAT_TWO 8'h14
`define USDB_OFS_DATA 8'h18
`define USDB_OFS_CTRL_THREE 8'h1c
`define USDB_OFS_RATE 8'h20
`define USDB_OFS_IRQ_STAT 8'h24
`define USDB_OFS_IRQ_MASK 8'h28
// serial_status_one fields
`define USDB_S1_RXFULL 5
`define USDB_S1_FE 1
`define USDB_S1_PE 0
// serial_status_two fields
`define USDB_S2_BKF 1
`define USDB_S2_RPF 0
// serial_control_three fields
`define USDB_C3_NINTH 7
`define USDB_C3_MODE9 4
`define USDB_C3_PAR_EN 3
`define USDB_C3_PAR_ODD 2
`define USDB_C3_FRAMING_ERROR_IRQ_ENABLE 1
`define USDB_C3_PARITY_ERROR_IRQ_ENABLE 0
// bit_rate_select fields
`define USDB_RATE_PS_LSB 4
`define USDB_RATE_RS_LSB 0
// irq status and mask fields
`define USDB_IRQ_FE 0
`define USDB_IRQ_PE 1
`define USDB_IRQ_RXFULL 2
// reset values
`define USDB_RST_CTRL 5'h00
`define USDB_RST_PS 2'h0
`define USDB_RST_RS 3'h0
`define USDB_RST_MASK 3'h0
// timing in sample slots
`define USDB_MID_SLOT 4'h7
`define USDB_LAST_SLOT 4'hf
`define USDB_IDLE_SLOTS 8'ha0
// bus responses
`define USDB_RESP_OKAY 2'h0
`define USDB_RESP_SLVERR 2'h2
`endif

// ### sim/usdb_remote_tx.sv
`timescale 1ns/10ps
module usdb_remote_tx (
  // clock
  input wire logic sys_clk_i,
  // serial line towards the receiver, idle high
  output logic rxd_o
);
  initial rxd_o = 1'b1;
  // a low stop is let go late in the bit, so the low that follows is dropped as a false start
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bt);
    rxd_o <= 1'b0;
    repeat (bt) @(posedge sys_clk_i);
    for (int i = 0; i < nb; i++) begin
      rxd_o <= d[i];
      repeat (bt) @(posedge sys_clk_i);
    end
    rxd_o <= stop;
    repeat ((3 * bt) / 4) @(posedge sys_clk_i);
    rxd_o <= 1'b1;
    repeat (bt / 4) @(posedge sys_clk_i);
  endtask : send
endmodule : usdb_remote_tx

// ### sim/usdb_serial_tb.sv
`timescale 1ns/10ps
`include "usdb_regs.svh"
module usdb_serial_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  int load_cnt = 0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxd, tx_load, err_irq, irq;
  logic [1:0] bresp, rresp, resp_q;
  logic [31:0] rdata, rd_q, rv;
  logic [7:0] tx_data;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int pd_tab[4] = '{1, 3, 4, 13};

  usdb_serial dut (.sys_clk_i(clk), .srst_i(srst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .rxd_i(rxd), .tx_data_o(tx_data), .tx_load_o(tx_load),
    .err_irq_o(err_irq), .irq_o(irq));
  usdb_remote_tx remote (.sys_clk_i(clk), .rxd_o(rxd));

  initial begin
    forever #4 clk = ~clk;
  end

  // counts transmit hand-off pulses seen at the edges
  always @(posedge clk) begin
    if (tx_load === 1'b1) begin
      load_cnt <= load_cnt + 1;
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] m = 32'hffffffff);
    tests_run++;
    if ((got & m) !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // ready is combinational on held inputs, so the negedge value is the edge value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    resp_q = bresp;
    @(posedge clk);
    bready <= 1'b0;
    // idle edge so a following call never re-drives ready in the same step
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    rd_q = rdata;
    resp_q = rresp;
    @(posedge clk);
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m = 32'hffffffff);
    rd(a);
    chk(rd_q, e, m);
  endtask : rd_chk

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_chk(`USDB_OFS_RATE, 32'h0);
    rd_chk(`USDB_OFS_STAT_ONE, 32'h0, 32'h23);
    rd_chk(`USDB_OFS_STAT_TWO, 32'h0, 32'h3);
    rd(8'h40);
    chk({30'h0, resp_q}, 32'h2);
    chk(rd_q, 32'h0);
    wr(8'h40, 32'h1);
    chk({30'h0, resp_q}, 32'h2);
    wr(`USDB_OFS_CTRL_THREE, 32'h02);
    chk({30'h0, resp_q}, 32'h0);
    wr(`USDB_OFS_IRQ_MASK, 32'h1);
    fork
      remote.send(9'h0a5, 8, 1'b1, 64);
      begin
        repeat (100) @(posedge clk);
        rd_chk(`USDB_OFS_STAT_TWO, 32'h1);
      end
    join
    repeat (4) @(posedge clk);
    rd_chk(`USDB_OFS_STAT_ONE, 32'h20, 32'h23);
    rd_chk(`USDB_OFS_DATA, 32'ha5);
    chk(err_irq, 32'h0);
    repeat (700) @(posedge clk);
    rd_chk(`USDB_OFS_STAT_TWO, 32'h0);
    remote.send(9'h0a5, 8, 1'b0, 64);
    repeat (4) @(posedge clk);
    chk(err_irq, 32'h1);
    chk(irq, 32'h1);
    rd_chk(`USDB_OFS_STAT_ONE, 32'h22, 32'h23);
    rd_chk(`USDB_OFS_DATA, 32'ha5);
    rd_chk(`USDB_OFS_STAT_ONE, 32'h0, 32'h23);
    chk(err_irq, 32'h0);
    wr(`USDB_OFS_IRQ_STAT, 32'h7);
    chk(irq, 32'h0);
    // even parity, parity event masked from irq_o
    wr(`USDB_OFS_CTRL_THREE, 32'h09);
    remote.send(9'h001, 8, 1'b1, 64);
    repeat (4) @(posedge clk);
    chk(err_irq, 32'h1);
    chk(irq, 32'h0);
    rd_chk(`USDB_OFS_STAT_ONE, 32'h21, 32'h23);
    rd_chk(`USDB_OFS_DATA, 32'h01);
    rd_chk(`USDB_OFS_STAT_ONE, 32'h0, 32'h23);
    wr(`USDB_OFS_CTRL_THREE, 32'h10);
    remote.send(9'h15a, 9, 1'b1, 64);
    repeat (4) @(posedge clk);
    rd_chk(`USDB_OFS_CTRL_THREE, 32'h90);
    rd_chk(`USDB_OFS_DATA, 32'h5a);
    remote.send(9'h000, 9, 1'b0, 64);
    repeat (4) @(posedge clk);
    rd_chk(`USDB_OFS_CTRL_THREE, 32'h10);
    rd_chk(`USDB_OFS_STAT_ONE, 32'h22, 32'h23);
    chk(err_irq, 32'h0);
    rd_chk(`USDB_OFS_STAT_TWO, 32'h2, 32'h2);
    rd_chk(`USDB_OFS_DATA, 32'h0);
    rd_chk(`USDB_OFS_STAT_TWO, 32'h0, 32'h2);
    wr(`USDB_OFS_CTRL_THREE, 32'h0);
    for (int k = 0; k < 4; k++) begin
      rv = {26'h0, 2'(k), 1'b0, 3'((k + 1) % 3)};
      wr(`USDB_OFS_RATE, rv);
      rd_chk(`USDB_OFS_RATE, rv);
      remote.send(9'(8'h3c + k), 8, 1'b1, 64 * pd_tab[k] * (1 << ((k + 1) % 3)));
      repeat (4) @(posedge clk);
      rd_chk(`USDB_OFS_DATA, 32'(8'h3c + k));
    end
    // mid-run reset: buffer keeps its byte, rate field returns to zero
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_chk(`USDB_OFS_DATA, 32'h3f);
    rd_chk(`USDB_OFS_RATE, 32'h0);
    wr(`USDB_OFS_DATA, 32'hc3);
    chk(tx_data, 32'hc3);
    wstrb <= 4'h0;
    wr(`USDB_OFS_DATA, 32'h5a);
    wstrb <= 4'h1;
    chk(tx_data, 32'hc3);
    chk({30'h0, resp_q}, 32'h0);
    chk(load_cnt, 32'h1);
    results();
  end
endmodule : usdb_serial_tb
